// file: hdl/sct_pkg.sv
// Shared constants for the sensor control register bank
package sct_pkg;
    // Register byte addresses
    localparam logic [7:0] SCT_ADDR_PART_CODE = 8'h00;
    localparam logic [7:0] SCT_ADDR_UNIT_LO = 8'h04;
    localparam logic [7:0] SCT_ADDR_UNIT_HI = 8'h0b;
    localparam logic [7:0] SCT_ADDR_CTRL = 8'h10;
    localparam logic [7:0] SCT_ADDR_STAT = 8'h11;
    localparam logic [7:0] SCT_ADDR_RUN_MODE = 8'h21;
    localparam logic [7:0] SCT_ADDR_START = 8'h22;
    localparam logic [7:0] SCT_ADDR_STOP = 8'h23;
    localparam logic [7:0] SCT_ADDR_MEAS_STAT = 8'h24;
    // Field positions
    localparam int SCT_CTRL_RESET_BIT = 7;
    localparam int SCT_CTRL_LOWPWR_BIT = 0;
    localparam int SCT_STAT_AWAKE_BIT = 0;
    localparam int SCT_HUM_BIT = 1;
    localparam int SCT_TEMP_BIT = 0;
    localparam int SCT_NSENS = 2;
    // Values after reset
    localparam logic [6:0] SCT_CTRL_RST = 7'h01;
    localparam logic [7:0] SCT_RUN_RST = 8'h00;
    localparam logic [7:0] SCT_ZERO_BYTE = 8'h00;
    // Arbitrary identification value, not tied to any real part
    localparam logic [15:0] SCT_PART_CODE = 16'h5a3c;
    // Wake-up time from standby, and its count at the 10 MHz clock
    localparam int SCT_CLK_MHZ = 10;
    localparam int SCT_BOOT_TIME_US = 1000;
    localparam int SCT_BOOT_CYCLES = SCT_BOOT_TIME_US * SCT_CLK_MHZ;
    // Sensor sequencer states
    typedef enum logic [1:0] {
        SCT_S_IDLE = 2'b01,
        SCT_S_MEAS = 2'b10
    } sct_sens_t;
    // System power states
    typedef enum logic [2:0] {
        SCT_P_BOOT = 3'b001,
        SCT_P_ACTIVE = 3'b010,
        SCT_P_STANDBY = 3'b100
    } sct_pwr_t;
endpackage

// file: hdl/sct_sensor_ctl.sv
// Per-sensor measurement sequencer: single shot or continuous
module sct_sensor_ctl
    import sct_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic soft_clr, // Software reset pulse
    input wire logic start, // Start command pulse
    input wire logic stop, // Stop command pulse
    input wire logic cont, // Continuous mode selected
    input wire logic done, // Engine finished one conversion
    output logic measuring // Sensor is measuring
);
    sct_sens_t state_r;
    sct_sens_t state_nxt;

    // Stop only ends a continuous run; a single shot ends on its own
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SCT_S_IDLE: begin
                if (start) begin
                    state_nxt = SCT_S_MEAS;
                end
            end
            SCT_S_MEAS: begin
                if (stop && cont) begin
                    state_nxt = SCT_S_IDLE;
                end else if (done && !cont && !start) begin
                    state_nxt = SCT_S_IDLE;
                end
            end
            default: state_nxt = SCT_S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SCT_S_IDLE;
        end else if (soft_clr) begin
            state_r <= SCT_S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign measuring = (state_r == SCT_S_MEAS);

    ////////////////////////////////////////////////////////////////////////////
    sequence idle_start_s;
        !measuring && start && !soft_clr;
    endsequence

    start_launch_a: assert property (@(posedge clk) disable iff (!rst_n)
        idle_start_s |=> measuring)
        else $error("start did not launch a measurement");

    stop_cont_a: assert property (@(posedge clk) disable iff (!rst_n)
        measuring && stop && cont |=> !measuring)
        else $error("stop did not end a continuous measurement");

    cont_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
        measuring && cont && !stop && !soft_clr |=> measuring)
        else $error("continuous measurement ended without stop");

    single_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        measuring && stop && !cont && !done && !soft_clr |=> measuring)
        else $error("stop ended a single-shot measurement");

    single_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        measuring && done && !cont && !start && !soft_clr |=> !measuring)
        else $error("single shot stayed busy after done");
endmodule // sct_sensor_ctl

// file: hdl/sct_regbank.sv
// Control and status registers of the humidity and temperature sensor
module sct_regbank
    import sct_pkg::*;
#(
    parameter int BOOT_CYCLES = SCT_BOOT_CYCLES // Wake-up length in clocks
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic reg_wr, // Write strobe, one cycle
    input wire logic reg_rd, // Read strobe, one cycle
    input wire logic [7:0] reg_wdata, // Write data byte
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    input wire logic [63:0] unit_id_value, // Unit identifier from non-volatile store
    input wire logic [SCT_NSENS-1:0] meas_done, // Conversion finished pulses
    output logic [SCT_NSENS-1:0] meas_busy, // Sensors measuring
    output logic engine_power, // Measurement engine powered
    output logic system_awake_flag // System is in active state
);
    localparam int CW = $clog2(BOOT_CYCLES + 1);
    localparam logic [CW-1:0] BOOT_LAST = CW'(BOOT_CYCLES - 1);

    logic [1:0] rst_sync_r;
    logic rst_n_s;
    logic soft_rst_r;
    logic [6:0] ctrl_r;
    logic [7:0] run_r;
    logic [7:0] rdata_r;
    sct_pwr_t pwr_r;
    sct_pwr_t pwr_nxt;
    logic [CW-1:0] boot_cnt_r;
    logic wr_ctrl;
    logic wr_run;
    logic wr_start;
    logic wr_stop;
    logic [SCT_NSENS-1:0] start_cmd;
    logic [SCT_NSENS-1:0] stop_cmd;
    logic [SCT_NSENS-1:0] busy;
    logic awake;
    logic low_power;
    logic [2:0] unit_idx;
    logic [7:0] unit_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion is still asynchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n_s = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    assign wr_ctrl = reg_wr && (reg_addr == SCT_ADDR_CTRL);
    assign wr_run = reg_wr && (reg_addr == SCT_ADDR_RUN_MODE);
    assign wr_start = reg_wr && (reg_addr == SCT_ADDR_START);
    assign wr_stop = reg_wr && (reg_addr == SCT_ADDR_STOP);

    // Only ones act, so one write can address one sensor alone
    assign start_cmd = wr_start ? reg_wdata[SCT_NSENS-1:0] : '0;
    assign stop_cmd = wr_stop ? reg_wdata[SCT_NSENS-1:0] : '0;

    assign low_power = ctrl_r[SCT_CTRL_LOWPWR_BIT];
    assign awake = (pwr_r == SCT_P_ACTIVE);

    ////////////////////////////////////////////////////////////////////////////
    // Software reset: a one-cycle pulse that restores control and run mode, idles both sensors and starts a boot
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_ctrl && reg_wdata[SCT_CTRL_RESET_BIT];
        end
    end

    // System control; the reset bit is not stored, so it reads back zero
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl_r <= SCT_CTRL_RST;
        end else if (soft_rst_r) begin
            ctrl_r <= SCT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata[6:0];
        end
    end

    // Run-mode selection, both sensors
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            run_r <= SCT_RUN_RST;
        end else if (soft_rst_r) begin
            run_r <= SCT_RUN_RST;
        end else if (wr_run) begin
            run_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state: standby only when idle, so a measurement is never cut short
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            SCT_P_ACTIVE: begin
                if (low_power && (busy == '0) && (start_cmd == '0)) begin
                    pwr_nxt = SCT_P_STANDBY;
                end
            end
            SCT_P_STANDBY: begin
                if (!low_power || (start_cmd != '0)) begin
                    pwr_nxt = SCT_P_BOOT;
                end
            end
            SCT_P_BOOT: begin
                if (boot_cnt_r == BOOT_LAST) begin
                    pwr_nxt = SCT_P_ACTIVE;
                end
            end
            default: pwr_nxt = SCT_P_BOOT;
        endcase
    end

    // Power state register; a software reset goes through a fresh boot
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pwr_r <= SCT_P_ACTIVE;
        end else if (soft_rst_r) begin
            pwr_r <= SCT_P_BOOT;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // Boot timer, counts only while booting
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            boot_cnt_r <= '0;
        end else if (pwr_r != SCT_P_BOOT || soft_rst_r) begin
            boot_cnt_r <= '0;
        end else if (boot_cnt_r != BOOT_LAST) begin
            boot_cnt_r <= boot_cnt_r + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One sequencer per sensor; bit 1 humidity, bit 0 temperature
    for (genvar g = 0; g < SCT_NSENS; g++) begin : g_sens
        sct_sensor_ctl u_ctl (
            .clk(clk),
            .rst_n(rst_n_s),
            .soft_clr(soft_rst_r),
            .start(start_cmd[g]),
            .stop(stop_cmd[g]),
            .cont(run_r[g]),
            .done(meas_done[g] && awake),
            .measuring(busy[g])
        );
    end

    assign meas_busy = busy;
    // The engine only sees power once boot is over, so results wait for it
    assign engine_power = awake;
    assign system_awake_flag = awake;

    ////////////////////////////////////////////////////////////////////////////
    // Identifier byte, lowest address holds the least significant byte
    assign unit_idx = 3'(reg_addr - SCT_ADDR_UNIT_LO);
    assign unit_byte = unit_id_value[{unit_idx, 3'b000} +: 8];

    // Read data; identifiers read zero outside the active state
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rdata_r <= SCT_ZERO_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == SCT_ADDR_PART_CODE) begin
                rdata_r <= awake ? SCT_PART_CODE[7:0] : SCT_ZERO_BYTE;
            end else if (reg_addr == SCT_ADDR_PART_CODE + 8'h01) begin
                rdata_r <= awake ? SCT_PART_CODE[15:8] : SCT_ZERO_BYTE;
            end else if (reg_addr >= SCT_ADDR_UNIT_LO && reg_addr <= SCT_ADDR_UNIT_HI) begin
                rdata_r <= awake ? unit_byte : SCT_ZERO_BYTE;
            end else if (reg_addr == SCT_ADDR_CTRL) begin
                rdata_r <= {1'b0, ctrl_r};
            end else if (reg_addr == SCT_ADDR_STAT) begin
                rdata_r <= {7'h00, awake};
            end else if (reg_addr == SCT_ADDR_RUN_MODE) begin
                rdata_r <= run_r;
            end else if (reg_addr == SCT_ADDR_MEAS_STAT) begin
                rdata_r <= {6'h00, busy};
            end else begin
                rdata_r <= SCT_ZERO_BYTE; // Stop, start and unmapped read zero
            end
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    sequence rd_s(logic [7:0] a);
        reg_rd && (reg_addr == a);
    endsequence

    sequence reset_write_s;
        wr_ctrl && reg_wdata[SCT_CTRL_RESET_BIT];
    endsequence

    id_hidden_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_PART_CODE) ##0 !awake |=> reg_rdata == SCT_ZERO_BYTE)
        else $error("part code visible outside active state");

    id_shown_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_PART_CODE) ##0 awake |=> reg_rdata == SCT_PART_CODE[7:0])
        else $error("part code low byte wrong");

    unit_hidden_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_UNIT_LO) ##0 !awake |=> reg_rdata == SCT_ZERO_BYTE)
        else $error("identifier visible outside active state");

    soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        reset_write_s |=> soft_rst_r ##1 (ctrl_r == SCT_CTRL_RST && run_r == SCT_RUN_RST
            && busy == '0 && pwr_r == SCT_P_BOOT))
        else $error("software reset did not restore defaults");

    stay_awake_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        awake && !low_power && !soft_rst_r |=> awake)
        else $error("left active state with low power disabled");

    no_sleep_busy_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        awake && busy != '0 |=> pwr_r != SCT_P_STANDBY)
        else $error("standby entered while measuring");

    stat_read_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_STAT) |=> reg_rdata == {7'h00, $past(awake)})
        else $error("system status read wrong");

    run_rw_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        wr_run && !soft_rst_r |=> run_r == $past(reg_wdata))
        else $error("run-mode write did not land");

    run_rd_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_RUN_MODE) |=> reg_rdata == $past(run_r))
        else $error("run-mode read back wrong");

    zero_no_start_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        wr_start && !reg_wdata[SCT_HUM_BIT] && !busy[SCT_HUM_BIT] && !soft_rst_r
            |=> !busy[SCT_HUM_BIT])
        else $error("zero start bit launched humidity");

    meas_stat_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_MEAS_STAT) |=> reg_rdata == {6'h00, $past(busy)})
        else $error("measuring status read wrong");

    id_high_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_PART_CODE + 8'h01) ##0 awake |=> reg_rdata == SCT_PART_CODE[15:8])
        else $error("part code high byte wrong");

    unit_shown_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_UNIT_LO) ##0 awake |=> reg_rdata == $past(unit_id_value[7:0]))
        else $error("identifier low byte wrong");

    ctrl_read_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        rd_s(SCT_ADDR_CTRL) |=> !reg_rdata[SCT_CTRL_RESET_BIT])
        else $error("reset bit read back as one");

    go_standby_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        awake && low_power && busy == '0 && start_cmd == '0 && !soft_rst_r |=> !awake)
        else $error("idle with low power but stayed active");

    start_wake_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        pwr_r == SCT_P_STANDBY && start_cmd != '0 && !soft_rst_r |=> pwr_r == SCT_P_BOOT)
        else $error("start in standby did not begin a boot");

    boot_end_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        pwr_r == SCT_P_BOOT && boot_cnt_r == BOOT_LAST && !soft_rst_r |=> awake)
        else $error("boot did not end in active state");

    zero_no_stop_a: assert property (@(posedge clk) disable iff (!rst_n_s)
        wr_stop && !reg_wdata[SCT_HUM_BIT] && busy[SCT_HUM_BIT] && run_r[SCT_HUM_BIT]
            && !soft_rst_r |=> busy[SCT_HUM_BIT])
        else $error("zero stop bit ended humidity");
endmodule // sct_regbank

// file: tb/sct_host_model.sv
// Host model: byte reads and writes on the register port
module sct_host_model
    import sct_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic [7:0] reg_rdata, // Read data from the bank
    output logic [7:0] reg_addr, // Register byte address
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_wdata // Write data byte
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Reserved bits always go out as zeros
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
        if (a == SCT_ADDR_CTRL) begin
            return d & 8'h81;
        end
        return d & 8'h03;
    endfunction
    // One write; released lines show inverted data so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = legal(a, d);
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    // One read; data is taken half a cycle after the sampling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // sct_host_model

// file: tb/testbench.sv
// Self-checking bench of the sensor control register bank
module testbench
    import sct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rb;
    logic reg_wr, reg_rd, engine_power, system_awake_flag;
    logic [63:0] unit_id_value;
    logic [1:0] meas_done, meas_busy;
    int fail_count, n_compared, seed, ctrl_m, run_m, busy_m, awake_m;
    ////////////////////////////////////////////////////////////////////////
    // Design, shortened wake-up so boots take a handful of cycles
    sct_regbank #(.BOOT_CYCLES(8)) DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .unit_id_value(unit_id_value), .meas_done(meas_done), .meas_busy(meas_busy),
        .engine_power(engine_power), .system_awake_flag(system_awake_flag));
    sct_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Reference read value from the bench's own register image
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a <= 8'h01) return awake_m ? 8'(SCT_PART_CODE >> (8 * a)) : 8'h00;
        if (a >= 8'h04 && a <= 8'h0b)
            return awake_m ? 8'(unit_id_value >> (8 * (a - 4))) : 8'h00;
        case (a)
            8'h10: return 8'(ctrl_m);
            8'h11: return 8'(awake_m);
            8'h21: return 8'(run_m);
            8'h24: return 8'(busy_m);
            default: return 8'h00;
        endcase
    endfunction
    task automatic rd_chk(input logic [7:0] a);
        host.rd(a, rb);
        check($sformatf("register %h", a), rb, exp_rd(a));
        check("busy pins", 8'(meas_busy), 8'(busy_m));
    endtask
    // Write through the host and update the reference image
    task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a == 8'h10 && d[7]) begin
            ctrl_m = 1;
            run_m = 0;
            busy_m = 0;
            awake_m = 0;
        end else if (a == 8'h10) ctrl_m = d & 8'h7f;
        else if (a == 8'h21) run_m = d;
        else if (a == 8'h22) busy_m = busy_m | d;
        else if (a == 8'h23) busy_m = busy_m & ~(d & run_m);
    endtask
    // Bounded wait for the power flag, engine supply must follow it
    task automatic wait_awake(input logic v);
        int i;
        for (i = 0; i < 40 && system_awake_flag !== v; i++) @(negedge clk);
        if (i == 40) begin
            check("awake flag", 8'(system_awake_flag), 8'(v));
            test_done();
        end
        check("engine power", 8'(engine_power), 8'(v));
        awake_m = v;
    endtask
    task automatic pulse_done(input logic [1:0] d);
        @(negedge clk);
        meas_done = d;
        @(negedge clk);
        meas_done = 2'b00;
        busy_m = busy_m & ~(d & ~run_m);
        check("busy after done", 8'(meas_busy), 8'(busy_m));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] regs [9] = '{8'h00, 8'h04, 8'h10, 8'h11, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
        fail_count = 0;
        n_compared = 0;
        seed = 76;
        rstn = 1'b0;
        meas_done = 2'b00;
        unit_id_value = {$random(seed), $random(seed)};
        repeat (10) @(negedge clk);
        check("awake in reset", 8'(system_awake_flag), 8'h01);
        check("busy in reset", 8'(meas_busy), 8'h00);
        rstn = 1'b1;
        repeat (5) @(negedge clk);
        ctrl_m = 1;
        run_m = 0;
        busy_m = 0;
        awake_m = 0;
        foreach (regs[i]) rd_chk(regs[i]);
        $display("test reset values done");
        // Leave low power, wait for active, then fetch the identifiers
        wr_m(8'h10, 8'h00);
        wait_awake(1'b1);
        for (int a = 0; a < 12; a++) rd_chk(8'(a));
        $display("test identifiers done");
        // Every run-mode pair: start both, stop one, finish, stop both
        for (int m = 0; m < 4; m++) begin
            wr_m(8'h21, 8'(m));
            rd_chk(8'h21);
            wr_m(8'h22, 8'h03);
            rd_chk(8'h24);
            wr_m(8'h23, 8'h01);
            rd_chk(8'h24);
            pulse_done(2'b11);
            wr_m(8'h23, 8'h03);
            rd_chk(8'h24);
        end
        wr_m(8'h21, 8'($random(seed)) & 8'h03);
        rd_chk(8'h21);
        wr_m(8'h22, 8'h02);
        rd_chk(8'h24);
        pulse_done(2'b10);
        wr_m(8'h23, 8'h02);
        rd_chk(8'h24);
        $display("test run modes done");
        // Automatic low power: standby, wake on start, standby after done
        wr_m(8'h10, 8'h01);
        wait_awake(1'b0);
        rd_chk(8'h11);
        rd_chk(8'h00);
        rd_chk(8'h05);
        wr_m(8'h21, 8'h00);
        wr_m(8'h22, 8'h01);
        check("busy in standby", 8'(meas_busy), 8'h01);
        wait_awake(1'b1);
        pulse_done(2'b01);
        wait_awake(1'b0);
        $display("test low power done");
        // Software reset clears modes and boots again
        wr_m(8'h21, 8'h03);
        wr_m(8'h22, 8'h03);
        wr_m(8'h10, 8'h80);
        wait_awake(1'b1);
        rd_chk(8'h21);
        rd_chk(8'h10);
        rd_chk(8'h24);
        $display("test software reset done");
        test_done();
    end
endmodule // testbench
